// *** line_irq_pkg.sv ***
// Purpose: Shared constants and carriers for the line interrupt block
// Assumes: One core clock, register access by address and channel select
// Notes:   Offsets are register addresses as seen on the access port
package line_irq_pkg;

    // ************************************************************
    // Register addresses
    // ************************************************************
    localparam logic [7:0] ADDR_SUMMARY      = 8'h0E;
    localparam logic [7:0] ADDR_TIMER_STATUS = 8'h0F;
    localparam logic [7:0] ADDR_LINE_STATUS  = 8'h10;
    localparam logic [7:0] ADDR_ALARM_STATUS = 8'h11;
    localparam logic [7:0] ADDR_TIMER_ENABLE = 8'h12;
    localparam logic [7:0] ADDR_LINE_ENABLE  = 8'h13;
    localparam logic [7:0] ADDR_ALARM_ENABLE = 8'h14;

    // ************************************************************
    // Implemented bit masks and reset values
    // ************************************************************
    localparam logic [7:0] TIMER_MASK   = 8'hF0;
    localparam logic [7:0] LINE_MASK    = 8'h3F;
    localparam logic [7:0] ALARM_MASK   = 8'hBF;
    localparam logic [7:0] BYTE_RESET   = 8'h00;
    localparam logic [7:0] SUMMARY_RESET = 8'h00;
    localparam logic [7:0] READ_IDLE    = 8'h00;

    // ************************************************************
    // Summary register layout
    // ************************************************************
    localparam int SUM_CHAN_A_LSB = 0;
    localparam int SUM_CHAN_B_LSB = 4;
    localparam int SUM_RESERVED   = 3;
    localparam int SUM_CLOCK_FAIL = 7;

    // ************************************************************
    // Line status bit positions
    // ************************************************************
    localparam int LINE_RING_TRIP    = 0;
    localparam int LINE_LOOP_CLOSURE = 1;
    localparam int LINE_GROUND_KEY   = 2;

    localparam int NUM_CHAN = 2;

    // Per channel events: detect fields are live levels, rest pulses
    typedef struct packed {
        logic [3:0] timer;
        logic       ram_access;
        logic       tone_detect;
        logic       voltage_track;
        logic       ground_key;
        logic       loop_closure;
        logic       ring_trip;
        logic       common_balance;
        logic [5:0] power_alarm;
    } chan_events_t;

    // One register access request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic       chan;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

endpackage

// *** sticky_flag_byte.sv ***
// Purpose: One byte of sticky pending flags
// Assumes: Set inputs are one-cycle pulses on the core clock
// Notes:   A set in the cycle of a write wins over the written zero
module sticky_flag_byte #(
    parameter logic [7:0] MASK = 8'hFF
) (
    // Clock and reset
    input  wire logic       i_core_clk,
    input  wire logic       i_nrst,
    // Events and software access
    input  wire logic [7:0] i_set,
    input  wire logic       i_wr,
    input  wire logic [7:0] i_wdata,
    // Flags
    output logic      [7:0] o_flags
);

    logic [7:0] next_flags;

    always_comb begin
        next_flags = ((i_wr ? i_wdata : o_flags) | i_set) & MASK;
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_flags <= line_irq_pkg::BYTE_RESET;
        end else begin
            o_flags <= next_flags;
        end
    end

endmodule

// *** dual_channel_line_irq_status.sv ***
// Purpose: Interrupt status, enables and summary for two line channels
// Assumes: Event and detect inputs come from logic on the core clock
// Notes:   Read data appear one cycle after the read request

module dual_channel_line_irq_status (
    // Clock and reset
    input  wire logic                      i_core_clk,
    input  wire logic                      i_nrst,
    // Register access
    input  wire line_irq_pkg::reg_req_t    i_reg_req,
    output logic                           o_reg_rvalid,
    output logic                     [7:0] o_reg_rdata,
    // Mode and clock monitor
    input  wire logic                      i_gci_mode,
    input  wire logic                      i_clock_fail_pending,
    // Channel events
    input  wire line_irq_pkg::chan_events_t [1:0] i_events,
    // Summary for the interrupt pin logic
    output logic                     [7:0] o_summary
);

    // ************************************************************
    // Declarations
    // ************************************************************
    logic [7:0] timer_event_status  [2];
    logic [7:0] line_event_status   [2];
    logic [7:0] alarm_event_status  [2];
    logic [7:0] timer_event_enable  [2];
    logic [7:0] line_event_enable   [2];
    logic [7:0] alarm_event_enable  [2];
    logic [7:0] timer_set           [2];
    logic [7:0] line_set            [2];
    logic [7:0] alarm_set           [2];
    logic [2:0] detect_prev         [2];
    logic [2:0] byte_pending        [2];
    logic [7:0] channel_summary_status;
    logic [7:0] next_summary;
    logic [7:0] next_rdata;
    logic [7:0] sel_timer_status;
    logic [7:0] sel_line_status;
    logic [7:0] sel_alarm_status;
    logic [7:0] sel_timer_enable;
    logic [7:0] sel_line_enable;
    logic [7:0] sel_alarm_enable;
    logic       chan_a_byte1_pending;
    logic       chan_a_byte2_pending;
    logic       chan_a_byte3_pending;
    logic       chan_b_byte1_pending;
    logic       chan_b_byte2_pending;
    logic       chan_b_byte3_pending;
    logic       clock_fail_pending;
    logic       status_wr_ok;

    // Status bytes take software writes in GCI mode only
    assign status_wr_ok = i_reg_req.wr & i_gci_mode;

    // ************************************************************
    // Per channel status and enables
    // ************************************************************
    for (genvar ch = 0; ch < line_irq_pkg::NUM_CHAN; ch++) begin : g_chan
        logic sel;
        logic [2:0] detect_now;
        logic [2:0] detect_rise;

        assign sel = (i_reg_req.chan == 1'(ch));
        assign detect_now = {i_events[ch].ground_key,
                             i_events[ch].loop_closure,
                             i_events[ch].ring_trip};
        // Live detects are levels; their rise is kept as history
        assign detect_rise = detect_now & ~detect_prev[ch];

        always_ff @(posedge i_core_clk or negedge i_nrst) begin
            if (!i_nrst) begin
                detect_prev[ch] <= 3'h0;
            end else begin
                detect_prev[ch] <= detect_now;
            end
        end

        // Events are recorded only while enabled
        assign timer_set[ch] = {i_events[ch].timer, 4'h0}
                               & timer_event_enable[ch];
        assign line_set[ch] = {2'h0,
                               i_events[ch].ram_access,
                               i_events[ch].tone_detect,
                               i_events[ch].voltage_track,
                               detect_rise}
                              & line_event_enable[ch];
        assign alarm_set[ch] = {i_events[ch].common_balance, 1'h0,
                                i_events[ch].power_alarm}
                               & alarm_event_enable[ch];

        sticky_flag_byte #(
            .MASK (line_irq_pkg::TIMER_MASK)
        ) u_timer (
            .i_core_clk (i_core_clk),
            .i_nrst     (i_nrst),
            .i_set      (timer_set[ch]),
            .i_wr       (status_wr_ok & sel & (i_reg_req.addr ==
                         line_irq_pkg::ADDR_TIMER_STATUS)),
            .i_wdata    (i_reg_req.wdata),
            .o_flags    (timer_event_status[ch])
        );

        sticky_flag_byte #(
            .MASK (line_irq_pkg::LINE_MASK)
        ) u_line (
            .i_core_clk (i_core_clk),
            .i_nrst     (i_nrst),
            .i_set      (line_set[ch]),
            .i_wr       (status_wr_ok & sel & (i_reg_req.addr ==
                         line_irq_pkg::ADDR_LINE_STATUS)),
            .i_wdata    (i_reg_req.wdata),
            .o_flags    (line_event_status[ch])
        );

        sticky_flag_byte #(
            .MASK (line_irq_pkg::ALARM_MASK)
        ) u_alarm (
            .i_core_clk (i_core_clk),
            .i_nrst     (i_nrst),
            .i_set      (alarm_set[ch]),
            .i_wr       (status_wr_ok & sel & (i_reg_req.addr ==
                         line_irq_pkg::ADDR_ALARM_STATUS)),
            .i_wdata    (i_reg_req.wdata),
            .o_flags    (alarm_event_status[ch])
        );

        // Enable registers, reserved bits held at zero
        always_ff @(posedge i_core_clk or negedge i_nrst) begin
            if (!i_nrst) begin
                timer_event_enable[ch] <= line_irq_pkg::BYTE_RESET;
                line_event_enable[ch]  <= line_irq_pkg::BYTE_RESET;
                alarm_event_enable[ch] <= line_irq_pkg::BYTE_RESET;
            end else if (i_reg_req.wr && sel) begin
                if (i_reg_req.addr == line_irq_pkg::ADDR_TIMER_ENABLE) begin
                    timer_event_enable[ch] <= i_reg_req.wdata
                        & line_irq_pkg::TIMER_MASK;
                end
                if (i_reg_req.addr == line_irq_pkg::ADDR_LINE_ENABLE) begin
                    line_event_enable[ch] <= i_reg_req.wdata
                        & line_irq_pkg::LINE_MASK;
                end
                if (i_reg_req.addr == line_irq_pkg::ADDR_ALARM_ENABLE) begin
                    alarm_event_enable[ch] <= i_reg_req.wdata
                        & line_irq_pkg::ALARM_MASK;
                end
            end
        end

        // A byte pends while any enabled flag in it is set
        assign byte_pending[ch] = {
            |(alarm_event_status[ch] & alarm_event_enable[ch]),
            |(line_event_status[ch] & line_event_enable[ch]),
            |(timer_event_status[ch] & timer_event_enable[ch])
        };
    end

    // ************************************************************
    // Shared summary register
    // ************************************************************
    assign chan_a_byte1_pending = byte_pending[0][0];
    assign chan_a_byte2_pending = byte_pending[0][1];
    assign chan_a_byte3_pending = byte_pending[0][2];
    assign chan_b_byte1_pending = byte_pending[1][0];
    assign chan_b_byte2_pending = byte_pending[1][1];
    assign chan_b_byte3_pending = byte_pending[1][2];
    assign clock_fail_pending   = i_clock_fail_pending;

    always_comb begin
        next_summary = line_irq_pkg::SUMMARY_RESET;
        next_summary[line_irq_pkg::SUM_CHAN_A_LSB +: 3] =
            {chan_a_byte3_pending, chan_a_byte2_pending,
             chan_a_byte1_pending};
        next_summary[line_irq_pkg::SUM_CHAN_B_LSB +: 3] =
            {chan_b_byte3_pending, chan_b_byte2_pending,
             chan_b_byte1_pending};
        next_summary[line_irq_pkg::SUM_CLOCK_FAIL] =
            clock_fail_pending;
    end

    // Read-only: no write path reaches this register
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            channel_summary_status <= line_irq_pkg::SUMMARY_RESET;
        end else begin
            channel_summary_status <= next_summary;
        end
    end

    assign o_summary = channel_summary_status;

    // ************************************************************
    // Read path
    // ************************************************************
    assign sel_timer_status = timer_event_status[i_reg_req.chan];
    assign sel_line_status  = line_event_status[i_reg_req.chan];
    assign sel_alarm_status = alarm_event_status[i_reg_req.chan];
    assign sel_timer_enable = timer_event_enable[i_reg_req.chan];
    assign sel_line_enable  = line_event_enable[i_reg_req.chan];
    assign sel_alarm_enable = alarm_event_enable[i_reg_req.chan];

    always_comb begin
        case (i_reg_req.addr)
            line_irq_pkg::ADDR_SUMMARY:      next_rdata =
                channel_summary_status;
            line_irq_pkg::ADDR_TIMER_STATUS: next_rdata = sel_timer_status;
            line_irq_pkg::ADDR_LINE_STATUS:  next_rdata = sel_line_status;
            line_irq_pkg::ADDR_ALARM_STATUS: next_rdata = sel_alarm_status;
            line_irq_pkg::ADDR_TIMER_ENABLE: next_rdata = sel_timer_enable;
            line_irq_pkg::ADDR_LINE_ENABLE:  next_rdata = sel_line_enable;
            line_irq_pkg::ADDR_ALARM_ENABLE: next_rdata = sel_alarm_enable;
            default:                         next_rdata =
                line_irq_pkg::READ_IDLE;
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_reg_rdata  <= line_irq_pkg::READ_IDLE;
            o_reg_rvalid <= 1'b0;
        end else begin
            o_reg_rvalid <= i_reg_req.rd;
            if (i_reg_req.rd) begin
                o_reg_rdata <= next_rdata;
            end
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    a_summary_reserved_zero: assert property (
        @(posedge i_core_clk) disable iff (!i_nrst)
        o_summary[line_irq_pkg::SUM_RESERVED] == 1'b0
    ) else $error("summary reserved bit set");

    a_chan_a_pending: assert property (
        @(posedge i_core_clk) disable iff (!i_nrst)
        (timer_event_status[0] & timer_event_enable[0]) != 8'h00
        |=> o_summary[line_irq_pkg::SUM_CHAN_A_LSB]
    ) else $error("channel A timer byte pending not shown");

    a_chan_b_pending: assert property (
        @(posedge i_core_clk) disable iff (!i_nrst)
        (alarm_event_status[1] & alarm_event_enable[1]) == 8'h00
        |=> !o_summary[line_irq_pkg::SUM_CHAN_B_LSB + 2]
    ) else $error("channel B alarm byte pending without cause");

    a_clock_fail_bit: assert property (
        @(posedge i_core_clk) disable iff (!i_nrst)
        i_clock_fail_pending |=> o_summary[line_irq_pkg::SUM_CLOCK_FAIL]
    ) else $error("clock failure not reported in summary");

    a_status_reserved: assert property (
        @(posedge i_core_clk) disable iff (!i_nrst)
        timer_event_status[0][3:0] == 4'h0
        && line_event_status[1][7:6] == 2'h0
        && alarm_event_status[0][6] == 1'b0
    ) else $error("reserved status bit set");

    a_nongci_write_ignored: assert property (
        @(posedge i_core_clk) disable iff (!i_nrst)
        (i_reg_req.wr && !i_gci_mode && !i_reg_req.chan
         && i_reg_req.addr == line_irq_pkg::ADDR_LINE_STATUS
         && line_set[0] == 8'h00)
        |=> $stable(line_event_status[0])
    ) else $error("status changed by write outside GCI mode");

    a_gci_write_clears: assert property (
        @(posedge i_core_clk) disable iff (!i_nrst)
        (i_reg_req.wr && i_gci_mode && i_reg_req.chan
         && i_reg_req.addr == line_irq_pkg::ADDR_TIMER_STATUS
         && i_reg_req.wdata == 8'h00 && timer_set[1] == 8'h00)
        |=> timer_event_status[1] == 8'h00
    ) else $error("GCI write did not clear timer status");

    a_enable_write: assert property (
        @(posedge i_core_clk) disable iff (!i_nrst)
        (i_reg_req.wr && !i_reg_req.chan
         && i_reg_req.addr == line_irq_pkg::ADDR_LINE_ENABLE)
        |=> line_event_enable[0] ==
            ($past(i_reg_req.wdata) & line_irq_pkg::LINE_MASK)
    ) else $error("line enable write not stored");

    a_loop_history: assert property (
        @(posedge i_core_clk) disable iff (!i_nrst)
        ($rose(i_events[0].loop_closure)
         && line_event_enable[0][line_irq_pkg::LINE_LOOP_CLOSURE]
         && !i_reg_req.wr)
        |=> line_event_status[0][line_irq_pkg::LINE_LOOP_CLOSURE]
        ##1 (line_event_status[0][line_irq_pkg::LINE_LOOP_CLOSURE]
             || $past(i_reg_req.wr))
    ) else $error("loop closure history lost");

    a_alarm_masked: assert property (
        @(posedge i_core_clk) disable iff (!i_nrst)
        (!alarm_event_status[1][0] && !alarm_event_enable[1][0]
         && !(i_reg_req.wr && i_gci_mode))
        |=> !alarm_event_status[1][0]
    ) else $error("masked power alarm recorded");

    a_summary_read: assert property (
        @(posedge i_core_clk) disable iff (!i_nrst)
        (i_reg_req.rd && i_reg_req.addr == line_irq_pkg::ADDR_SUMMARY)
        |=> o_reg_rvalid && o_reg_rdata == $past(o_summary)
    ) else $error("summary read returned wrong data");

endmodule

// *** dual_channel_line_irq_status_tb.sv ***
// Purpose: Self-checking bench for the line interrupt status block
// Assumes: Reference model runs cycle by cycle beside the design
// Notes:   Random traffic comes from an LFSR seeded with 32'hbc53
module dual_channel_line_irq_status_tb;
    timeunit 1ns;
    timeprecision 100ps;

    // ************************************************************
    // Signals
    // ************************************************************
    logic                               clk  = 1'b0;
    logic                               nrst = 1'b0;
    line_irq_pkg::reg_req_t             req;
    logic                               rvalid;
    logic                         [7:0] rdata;
    logic                               gci;
    logic                               cfail;
    line_irq_pkg::chan_events_t   [1:0] ev;
    logic                         [7:0] summary;
    int                                 err_total;
    int                                 num_checks;
    logic                        [31:0] seed;
    logic                         [7:0] m_st [2][3];
    logic                         [7:0] m_en [2][3];
    logic                         [2:0] m_prev [2];
    logic                         [7:0] m_sum;
    logic                         [7:0] m_rd;
    logic                               m_rv;
    logic                         [7:0] s;
    logic                         [7:0] nv;
    logic                         [7:0] msk [3];

    dual_channel_line_irq_status i_dut (
        .i_core_clk           (clk),
        .i_nrst               (nrst),
        .i_reg_req            (req),
        .o_reg_rvalid         (rvalid),
        .o_reg_rdata          (rdata),
        .i_gci_mode           (gci),
        .i_clock_fail_pending (cfail),
        .i_events             (ev),
        .o_summary            (summary)
    );

    always #2.5 clk = ~clk;

    // ************************************************************
    // Reference model
    // ************************************************************
    function automatic logic [7:0] setv(line_irq_pkg::chan_events_t e,
                                        logic [2:0] p, int k);
        case (k)
            0: return {e.timer, 4'h0};
            1: return {2'b00, e.ram_access, e.tone_detect, e.voltage_track,
                       {e.ground_key, e.loop_closure, e.ring_trip} & ~p};
            default: return {e.common_balance, 1'b0, e.power_alarm};
        endcase
    endfunction

    function automatic logic [7:0] regval(logic [7:0] a, logic c);
        if (a == line_irq_pkg::ADDR_SUMMARY) return m_sum;
        if (a >= 8'h0F && a <= 8'h11) return m_st[c][a - 8'h0F];
        if (a >= 8'h12 && a <= 8'h14) return m_en[c][a - 8'h12];
        return 8'h00;
    endfunction

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int c = 0; c < 2; c++) begin
                m_prev[c] <= 3'h0;
                for (int k = 0; k < 3; k++) begin
                    m_st[c][k] <= 8'h00;
                    m_en[c][k] <= 8'h00;
                end
            end
            m_sum <= 8'h00;
            m_rd  <= 8'h00;
            m_rv  <= 1'b0;
        end else begin
            s = 8'h00;
            for (int c = 0; c < 2; c++) begin
                m_prev[c] <= {ev[c].ground_key, ev[c].loop_closure,
                              ev[c].ring_trip};
                for (int k = 0; k < 3; k++) begin
                    s[c * 4 + k] = |(m_st[c][k] & m_en[c][k]);
                    nv = m_st[c][k];
                    if (req.wr && req.chan == c[0] && gci
                        && req.addr == 8'h0F + k[7:0])
                        nv = req.wdata & msk[k];
                    m_st[c][k] <= nv | (setv(ev[c], m_prev[c], k)
                                        & m_en[c][k]);
                    if (req.wr && req.chan == c[0]
                        && req.addr == 8'h12 + k[7:0])
                        m_en[c][k] <= req.wdata & msk[k];
                end
            end
            s[7] = cfail;
            m_sum <= s;
            m_rv  <= req.rd;
            if (req.rd)
                m_rd <= regval(req.addr, req.chan);
        end
    end

    // ************************************************************
    // Checking and closing
    // ************************************************************
    task automatic check(input string nm, input logic [7:0] seen,
                         input logic [7:0] exp);
        num_checks++;
        if (seen !== exp || $isunknown(seen)) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    always @(negedge clk) begin
        check("summary", summary, m_sum);
        check("rvalid", {7'h00, rvalid}, {7'h00, m_rv});
        if (m_rv)
            check("rdata", rdata, m_rd);
    end

    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ************************************************************
    // Stimulus
    // ************************************************************
    function automatic logic [31:0] lfsr(logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic acc(input logic w, input logic r, input logic c,
                       input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{wr: w, rd: r, chan: c, addr: a, wdata: d};
        @(posedge clk);
        req <= '0;
    endtask

    task automatic sweep(input logic [7:0] d, input logic w);
        for (int c = 0; c < 2; c++) begin
            for (int a = 8'h0D; a <= 8'h15; a++) begin
                if (w)
                    acc(1'b1, 1'b0, c[0], a[7:0], d);
                acc(1'b0, 1'b1, c[0], a[7:0], 8'h00);
            end
        end
    endtask

    task automatic rnd_step;
        logic [31:0] r1;
        logic [31:0] r2;
        logic [31:0] r3;
        seed = lfsr(lfsr(seed));
        r1 = seed;
        seed = lfsr(lfsr(seed));
        r2 = seed;
        seed = lfsr(lfsr(seed));
        r3 = seed;
        @(posedge clk);
        ev    <= (34'(r1) & 34'(r2) & 34'(r3)) ^ 34'({r3[3:0], 30'h0});
        gci   <= r1[16] | r2[16];
        cfail <= r1[20] & r2[21] & r3[22];
        req   <= '{wr: r1[0] & r1[1] & r2[0], rd: r1[2], chan: r1[3],
                   addr: 8'h0D + {5'h00, r1[7:5]}, wdata: r3[15:8]};
    endtask

    initial begin
        msk = '{line_irq_pkg::TIMER_MASK, line_irq_pkg::LINE_MASK,
                line_irq_pkg::ALARM_MASK};
        req        = '0;
        gci        = 1'b0;
        cfail      = 1'b0;
        ev         = '0;
        err_total  = 0;
        num_checks = 0;
        seed       = 32'hbc53;
        repeat (7) @(posedge clk);
        @(negedge clk);
        check("reset summary", summary, line_irq_pkg::SUMMARY_RESET);
        @(posedge clk);
        nrst <= 1'b1;
        sweep(8'h00, 1'b0);
        $display("test reset values done");
        sweep(8'hFF, 1'b1);
        $display("test gci off writes done");
        acc(1'b0, 1'b1, 1'b0, line_irq_pkg::ADDR_TIMER_STATUS, 8'h00);
        @(negedge clk);
        check("locked status", rdata, 8'h00);
        @(posedge clk);
        gci <= 1'b1;
        sweep(8'hFF, 1'b1);
        repeat (3) @(posedge clk);
        @(negedge clk);
        check("all pending", summary, 8'h77);
        sweep(8'h00, 1'b1);
        $display("test gci on writes done");
        repeat (4000) rnd_step();
        @(posedge clk);
        req <= '0;
        ev  <= '0;
        repeat (4) @(posedge clk);
        $display("test random traffic done");
        nrst <= 1'b0;
        @(negedge clk);
        check("mid reset summary", summary, 8'h00);
        @(posedge clk);
        nrst <= 1'b1;
        sweep(8'h00, 1'b0);
        $display("test mid-run reset done");
        conclude();
    end

    initial begin
        #(6000 * 5);
        err_total++;
        conclude();
    end
endmodule
